// file: design/pde_defs.vh
// constants for the product data eeprom access engine
// assumes inclusion by bare name from design files
`ifndef PDE_DEFS_VH
`define PDE_DEFS_VH
`define PDE_ADDR_W 8
`define PDE_CS0_READ_LIMIT 8'hbf
`define PDE_HIDDEN_OFFSET 8'h40
`define PDE_CS0_WRITE_BASE 8'h40
`define PDE_ALT_WRITE_BASE 8'h40
`define PDE_BYTES_PER_XFER 3'h4
`define PDE_FLAG_BIT 31
`define PDE_ADDR_LSB 16
`define PDE_FLAG_RESET 1'b0
`define PDE_DATA_RESET 32'h00000000
`endif

// file: design/pde_sync.v
// three flop synchroniser with agreement filter for one pin level
// assumes the input comes from outside the core_clk domain
`timescale 1ns/1ps
module pde_sync (
    core_clk, // clock
    reset_n,  // async reset, active low
    pin_in,   // raw pin level
    level_out // filtered level
);
    input wire core_clk;
    input wire reset_n;
    input wire pin_in;
    output reg level_out;
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_out <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // change counts only once the last two stages agree
            if (s2_reg == s3_reg)
                level_out <= s3_reg;
        end
    end
endmodule

// file: design/pde_byte_port.v
// byte transfer port toward the serial eeprom controller
// assumes the controller answers each request with a one cycle done pulse
`timescale 1ns/1ps
module pde_byte_port (
    core_clk,  // clock
    reset_n,   // async reset, active low
    start,     // one cycle: begin a byte transfer
    wr,        // 1 write, 0 read
    cs,        // eeprom chip select
    addr,      // eeprom byte address
    wdata,     // byte to write
    ee_req,    // request toward controller, level until done
    ee_wr,     // direction of request
    ee_cs,     // chip select of request
    ee_addr,   // address of request
    ee_wdata,  // write byte of request
    ee_done,   // one cycle completion from controller
    ee_rdata,  // read byte from controller
    done,      // one cycle: byte finished
    rdata      // captured read byte
);
    input wire core_clk;
    input wire reset_n;
    input wire start;
    input wire wr;
    input wire [2:0] cs;
    input wire [7:0] addr;
    input wire [7:0] wdata;
    output reg ee_req;
    output reg ee_wr;
    output reg [2:0] ee_cs;
    output reg [7:0] ee_addr;
    output reg [7:0] ee_wdata;
    input wire ee_done;
    input wire [7:0] ee_rdata;
    output reg done;
    output reg [7:0] rdata;
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ee_req <= 1'b0;
            ee_wr <= 1'b0;
            ee_cs <= 3'h0;
            ee_addr <= 8'h00;
            ee_wdata <= 8'h00;
            done <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (start && !ee_req)
            begin
                ee_req <= 1'b1;
                ee_wr <= wr;
                ee_cs <= cs;
                ee_addr <= addr;
                ee_wdata <= wdata;
            end
            else if (ee_req && ee_done)
            begin
                ee_req <= 1'b0;
                done <= 1'b1;
                rdata <= ee_rdata;
            end
        end
    end
endmodule

// file: design/pde_engine.v
// product data eeprom access engine: four byte reads and writes
// assumes a serial eeprom controller that takes one byte request at a time
`timescale 1ns/1ps
`include "pde_defs.vh"
module pde_engine (
    core_clk,        // clock, 100 MHz
    reset_n,         // async reset, active low
    addr_wr,         // one cycle: address field and flag written
    addr_wdata,      // written address field
    flag_wdata,      // written flag, 1 write, 0 read
    data_wr,         // one cycle: data register written
    data_wdata,      // written data register value
    product_info_chip_select, // eeprom chip select
    product_info_enable,      // access enable
    eeprom_present_pin,       // eeprom present, from a pin
    product_info_address_field, // address field readback
    product_info_flag,          // flag readback
    product_info_data_register, // data register readback
    busy,            // transfer in progress
    ee_req,          // byte request toward controller
    ee_wr,           // byte request direction
    ee_cs,           // byte request chip select
    ee_addr,         // byte request address
    ee_wdata,        // byte request write data
    ee_done,         // byte completion pulse
    ee_rdata         // byte read data
);
    input wire core_clk;
    input wire reset_n;
    input wire addr_wr;
    input wire [7:0] addr_wdata;
    input wire flag_wdata;
    input wire data_wr;
    input wire [31:0] data_wdata;
    input wire [2:0] product_info_chip_select;
    input wire product_info_enable;
    input wire eeprom_present_pin;
    output reg [7:0] product_info_address_field;
    output reg product_info_flag;
    output reg [31:0] product_info_data_register;
    output wire busy;
    output wire ee_req;
    output wire ee_wr;
    output wire [2:0] ee_cs;
    output wire [7:0] ee_addr;
    output wire [7:0] ee_wdata;
    input wire ee_done;
    input wire [7:0] ee_rdata;

    // one-hot states: a single flop per state keeps the decode shallow
    localparam ST_IDLE = 3'b001;
    localparam ST_ISSUE = 3'b010;
    localparam ST_WAIT = 3'b100;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [7:0] eeprom_address;
        input [2:0] cs;
        input [7:0] a;
        begin
            if (cs == 3'h0)
                eeprom_address = a + `PDE_HIDDEN_OFFSET;
            else
                eeprom_address = a;
        end
    endfunction

    function write_allowed;
        input [2:0] cs;
        input [7:0] a;
        begin
            if (cs == 3'h0)
                write_allowed = (a >= `PDE_CS0_WRITE_BASE) && (a <= `PDE_CS0_READ_LIMIT);
            else
                write_allowed = (a >= `PDE_ALT_WRITE_BASE);
        end
    endfunction

    function read_allowed;
        input [2:0] cs;
        input [7:0] a;
        begin
            if (cs == 3'h0)
                read_allowed = (a <= `PDE_CS0_READ_LIMIT);
            else
                read_allowed = 1'b1;
        end
    endfunction

    // picks byte lane n of a doubleword; lane 0 is the lowest address
    function [7:0] lane_byte;
        input [31:0] word;
        input [1:0] n;
        begin
            lane_byte = word[{n, 3'b000} +: 8];
        end
    endfunction

    // replaces byte lane n of a doubleword, leaving the other lanes alone
    function [31:0] lane_merge;
        input [31:0] word;
        input [1:0] n;
        input [7:0] b;
        begin
            lane_merge = word;
            lane_merge[{n, 3'b000} +: 8] = b;
        end
    endfunction

    // true on the index of the last byte of a transfer
    function last_lane;
        input [1:0] n;
        begin
            last_lane = ({1'b0, n} == `PDE_BYTES_PER_XFER - 3'h1);
        end
    endfunction

    // value the flag takes when a request of this direction finishes
    function done_flag;
        input dir;
        begin
            done_flag = ~dir;
        end
    endfunction

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    // presence lags the pin by about four clocks; requests in that gap see the old level
    wire present;
    pde_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(eeprom_present_pin),
        .level_out(present)
    );

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // the controller takes one byte at a time, so each byte waits for the last done
    reg [2:0] state_reg;
    reg [1:0] idx_reg;
    reg dir_reg;
    reg [2:0] cs_reg;
    reg [7:0] base_reg;
    reg [31:0] shadow_reg;
    reg start;
    wire byte_done;
    wire [7:0] byte_rdata;
    wire [7:0] cur_addr;
    wire [7:0] cur_wbyte;

    // an 8-bit address wraps inside the same chip select
    assign cur_addr = eeprom_address(cs_reg, base_reg + {6'h00, idx_reg});
    assign cur_wbyte = lane_byte(shadow_reg, idx_reg);
    assign busy = (state_reg != ST_IDLE);

    always @*
    begin
        start = (state_reg == ST_ISSUE);
    end

    pde_byte_port u_port (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(start),
        .wr(dir_reg),
        .cs(cs_reg),
        .addr(cur_addr),
        .wdata(cur_wbyte),
        .ee_req(ee_req),
        .ee_wr(ee_wr),
        .ee_cs(ee_cs),
        .ee_addr(ee_addr),
        .ee_wdata(ee_wdata),
        .ee_done(ee_done),
        .ee_rdata(ee_rdata),
        .done(byte_done),
        .rdata(byte_rdata)
    );

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // refusals finish at once, so no eeprom access is ever started for them
    wire req_ok;
    // low two address bits ignored: software keeps requests aligned
    wire [7:0] aligned_addr;
    assign aligned_addr = {addr_wdata[7:2], 2'b00};
    assign req_ok = flag_wdata ? write_allowed(product_info_chip_select, aligned_addr)
                               : read_allowed(product_info_chip_select, aligned_addr);

    // ------------------------------------------------------------
    // request and result registers
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_IDLE;
            idx_reg <= 2'h0;
            dir_reg <= 1'b0;
            cs_reg <= 3'h0;
            base_reg <= 8'h00;
            shadow_reg <= `PDE_DATA_RESET;
            product_info_address_field <= 8'h00;
            product_info_flag <= `PDE_FLAG_RESET;
            product_info_data_register <= `PDE_DATA_RESET;
        end
        else
        begin
            // data writes while busy are dropped; results would be undefined anyway
            if (data_wr && state_reg == ST_IDLE)
            begin
                product_info_data_register <= data_wdata;
            end
            case (state_reg)
                ST_IDLE:
                begin
                    if (addr_wr)
                    begin
                        product_info_address_field <= aligned_addr;
                        product_info_flag <= flag_wdata;
                        dir_reg <= flag_wdata;
                        cs_reg <= product_info_chip_select;
                        base_reg <= aligned_addr;
                        // a data write in the same cycle as the address write wins
                        shadow_reg <= data_wr ? data_wdata : product_info_data_register;
                        idx_reg <= 2'h0;
                        if (!product_info_enable || !present)
                            product_info_flag <= done_flag(flag_wdata);
                        else if (!req_ok)
                            // refused request completes at once with no eeprom access
                            product_info_flag <= done_flag(flag_wdata);
                        else
                            state_reg <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (byte_done)
                    begin
                        if (!dir_reg)
                            shadow_reg <= lane_merge(shadow_reg, idx_reg, byte_rdata);
                        if (last_lane(idx_reg))
                        begin
                            state_reg <= ST_IDLE;
                            if (!dir_reg)
                            begin
                                product_info_data_register <= lane_merge(shadow_reg, idx_reg, byte_rdata);
                                product_info_flag <= 1'b1;
                            end
                            else
                                product_info_flag <= 1'b0;
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 2'h1;
                            state_reg <= ST_ISSUE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: dv/pde_engine_checker.sv
// checker for the product data eeprom engine, port level only
// assumes binding onto pde_engine, one clock domain
`timescale 1ns/1ps
module pde_engine_checker (
    input wire core_clk, // clock
    input wire reset_n, // async reset
    input wire addr_wr, // address write
    input wire [7:0] addr_wdata, // address
    input wire flag_wdata, // flag written
    input wire [2:0] product_info_chip_select, // chip select
    input wire product_info_enable, // enable
    input wire [7:0] product_info_address_field, // address readback
    input wire product_info_flag, // flag readback
    input wire [31:0] product_info_data_register, // data readback
    input wire busy, // busy
    input wire ee_req, // byte request
    input wire ee_wr, // direction
    input wire [2:0] ee_cs, // chip select
    input wire [7:0] ee_addr, // byte address
    input wire ee_done, // byte done
    input wire [7:0] ee_rdata // byte read data
);
    // ----------------------------------------
    // helper: byte count and captured read bytes
    // ----------------------------------------
    reg [2:0] cnt_reg;
    reg dir_reg;
    reg [31:0] shadow_reg;
    wire [7:0] rel = ee_addr - ((ee_cs == 3'h0) ? 8'h40 : 8'h00) - product_info_address_field;
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg <= 3'h0;
            dir_reg <= 1'b0;
            shadow_reg <= 32'h0;
        end
        else if (!busy)
            cnt_reg <= 3'h0;
        else if (ee_req && ee_done)
        begin
            cnt_reg <= cnt_reg + 3'h1;
            dir_reg <= ee_wr;
            if (!ee_wr)
                shadow_reg[8 * cnt_reg[1:0] +: 8] <= ee_rdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_req_held: assert property (ee_req && !ee_done |=> ee_req)
        else $error("byte request dropped before done");
    a_req_stable: assert property (ee_req && !ee_done |=> $stable({ee_wr, ee_cs, ee_addr}))
        else $error("byte request changed while pending");
    a_byte_order: assert property ($rose(ee_req) |-> rel == {6'h00, cnt_reg[1:0]} && ee_cs == product_info_chip_select)
        else $error("byte address out of sequence");
    a_done_drop: assert property (ee_req && ee_done |=> !ee_req)
        else $error("request not released after done");
    a_req_busy: assert property (ee_req |-> busy)
        else $error("request outside a transfer");
    a_busy_ignore: assert property (busy && addr_wr |=> $stable(product_info_address_field))
        else $error("address taken while busy");
    a_refuse_off: assert property (addr_wr && !busy && !product_info_enable |=> product_info_flag != $past(flag_wdata) ##1 !ee_req)
        else $error("disabled access not refused");
    a_cs0_read_top: assert property (addr_wr && !busy && product_info_chip_select == 3'h0 && !flag_wdata && addr_wdata > 8'hbf |=> product_info_flag && !ee_req ##1 !ee_req)
        else $error("read above limit not refused");
    a_low_protect: assert property (addr_wr && !busy && flag_wdata && addr_wdata < 8'h40 |=> !product_info_flag && !ee_req ##1 !ee_req)
        else $error("protected write not skipped");
    a_cs0_write_top: assert property (addr_wr && !busy && flag_wdata && product_info_chip_select == 3'h0 && addr_wdata > 8'hbf |=> !product_info_flag ##1 !ee_req)
        else $error("cs0 write above limit not skipped");
    a_end_result: assert property ($fell(busy) && cnt_reg == 3'h4 |-> product_info_flag == !dir_reg && (dir_reg || product_info_data_register == shadow_reg))
        else $error("wrong flag or data at end");
endmodule

// file: dv/pde_ee_model.sv
// behavioural serial eeprom controller on the byte handshake
// assumes requests held until done; answers after 0..3 idle cycles
`timescale 1ns/1ps
module pde_ee_model (
    input wire core_clk, // clock
    input wire reset_n, // async reset
    input wire ee_req, // byte request
    input wire ee_wr, // direction
    input wire [2:0] ee_cs, // chip select
    input wire [7:0] ee_addr, // byte address
    input wire [7:0] ee_wdata, // write byte
    output reg ee_done, // one cycle done
    output reg [7:0] ee_rdata // read byte
);
    reg [7:0] mem [0:2047];
    reg [1:0] wait_reg;
    reg [31:0] r;
    integer seed = 50952;
    integer i;
    initial
    begin
        for (i = 0; i < 2048; i = i + 1)
            mem[i] = i[7:0] ^ {i[10:8], 5'h0};
    end
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ee_done <= 1'b0;
            ee_rdata <= 8'h5a;
            wait_reg <= 2'h0;
        end
        else
        begin
            ee_done <= 1'b0;
            // read byte only valid with done, so keep it moving otherwise
            ee_rdata <= ~ee_rdata;
            if (ee_req && !ee_done && wait_reg != 2'h0)
                wait_reg <= wait_reg - 2'h1;
            else if (ee_req && !ee_done)
            begin
                r = $random(seed);
                wait_reg <= r[1:0];
                ee_done <= 1'b1;
                if (ee_wr)
                    mem[{ee_cs, ee_addr}] <= ee_wdata;
                else
                    ee_rdata <= mem[{ee_cs, ee_addr}];
            end
        end
    end
endmodule

// file: dv/tb_pde_engine.sv
// self-checking bench for the product data eeprom engine
// assumes pde_engine with the eeprom model on its byte port
`timescale 1ns/1ps
module tb_pde_engine;
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg addr_wr = 1'b0;
    reg [7:0] addr_wdata = 8'h00;
    reg flag_wdata = 1'b0;
    reg data_wr = 1'b0;
    reg [31:0] data_wdata = 32'h0;
    reg [2:0] cs = 3'h0;
    reg en = 1'b0;
    reg pres = 1'b0;
    wire [7:0] field;
    wire flag;
    wire [31:0] dreg;
    wire busy, ee_req, ee_wr, ee_done;
    wire [2:0] ee_cs;
    wire [7:0] ee_addr, ee_wdata, ee_rdata;
    integer seed = 50952;
    integer miscompares = 0;
    integer comparisons = 0;
    integer n;
    reg [31:0] r, d;
    reg [7:0] mirror [0:2047];
    reg [32:0] exp_q [$];
    reg [7:0] exp_field_q [$];
    reg [31:0] exp_data;
    event op_end;
    always #5 core_clk = ~core_clk;
    pde_engine pde_engine_inst (.core_clk(core_clk), .reset_n(reset_n), .addr_wr(addr_wr),
        .addr_wdata(addr_wdata), .flag_wdata(flag_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .product_info_chip_select(cs), .product_info_enable(en),
        .eeprom_present_pin(pres), .product_info_address_field(field),
        .product_info_flag(flag), .product_info_data_register(dreg), .busy(busy),
        .ee_req(ee_req), .ee_wr(ee_wr), .ee_cs(ee_cs), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata));
    pde_ee_model pde_ee_model_inst (.core_clk(core_clk), .reset_n(reset_n), .ee_req(ee_req),
        .ee_wr(ee_wr), .ee_cs(ee_cs), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .ee_done(ee_done), .ee_rdata(ee_rdata));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check_res(input [32:0] got, input [32:0] want);
    begin
        comparisons = comparisons + 1;
        if (got !== want)
        begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    end
    endtask
    task check_field(input [7:0] got, input [7:0] want);
    begin
        comparisons = comparisons + 1;
        if (got !== want)
        begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    end
    endtask
    task test_done;
    begin
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // one request: data first for writes, then address with flag
    task op(input [2:0] c, input [7:0] a, input w, input [31:0] dw, input e);
        reg ok;
        reg [7:0] off;
        integer i, t;
    begin
        off = (c == 3'h0) ? 8'h40 : 8'h00;
        ok = e && pres && (c != 3'h0 || a <= 8'hbf) && (!w || a >= 8'h40);
        @(posedge core_clk);
        en <= e;
        cs <= c;
        data_wr <= w;
        data_wdata <= dw;
        if (w)
            exp_data = dw;
        for (i = 0; i < 4; i = i + 1)
            if (ok && w)
                mirror[{c, a + off + i[7:0]}] = dw[8 * i +: 8];
            else if (ok)
                exp_data[8 * i +: 8] = mirror[{c, a + off + i[7:0]}];
        exp_q.push_back({~w, exp_data});
        exp_field_q.push_back(a);
        @(posedge core_clk);
        data_wr <= 1'b0;
        addr_wr <= 1'b1;
        addr_wdata <= a;
        flag_wdata <= w;
        @(posedge core_clk);
        addr_wr <= 1'b0;
        @(posedge core_clk);
        if (ok)
        begin
            addr_wr <= 1'b1;
            addr_wdata <= ~a;
        end
        @(posedge core_clk);
        addr_wr <= 1'b0;
        t = 0;
        @(negedge core_clk);
        while (busy !== 1'b0 && t < 500)
        begin
            @(negedge core_clk);
            t = t + 1;
        end
        if (t == 500)
            miscompares = miscompares + 1;
        -> op_end;
    end
    endtask
    // ----------------------------------------
    // result monitor and watchdog
    // ----------------------------------------
    initial
    begin
        forever
        begin
            @(op_end);
            check_res({flag, dreg}, exp_q.pop_front());
            check_field(field, exp_field_q.pop_front());
        end
    end
    initial
    begin
        #300000;
        miscompares = miscompares + 1;
        test_done;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        for (n = 0; n < 2048; n = n + 1)
            mirror[n] = n[7:0] ^ {n[10:8], 5'h0};
        exp_data = 32'h0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        pres <= 1'b1;
        repeat (8) @(posedge core_clk);
        for (n = 0; n < 60; n = n + 1)
        begin
            if (n % 20 == 19)
            begin
                @(posedge core_clk);
                pres <= ~pres;
                repeat (8) @(posedge core_clk);
            end
            r = $random(seed);
            d = $random(seed);
            op(r[2:0] & {3{r[3]}}, {r[9:4], 2'b00}, r[10], d, r[13:11] != 3'h0);
        end
        // mid-run reset: results return to zero, presence is brought back and resynchronised
        @(posedge core_clk);
        reset_n <= 1'b0;
        pres <= 1'b1;
        exp_data = 32'h0;
        exp_q.push_back(33'h0);
        exp_field_q.push_back(8'h00);
        repeat (2) @(negedge core_clk);
        -> op_end;
        @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        op(3'h0, 8'h80, 1'b1, 32'h8c4d2e1f, 1'b1);
        op(3'h0, 8'h80, 1'b0, 32'h0, 1'b1);
        op(3'h0, 8'hbc, 1'b0, 32'h0, 1'b1);
        op(3'h0, 8'hc0, 1'b0, 32'h0, 1'b1);
        op(3'h0, 8'h3c, 1'b1, 32'h11223344, 1'b1);
        op(3'h0, 8'hc0, 1'b1, 32'h55667788, 1'b1);
        op(3'h5, 8'hfc, 1'b1, 32'ha1b2c3d4, 1'b1);
        op(3'h5, 8'hfc, 1'b0, 32'h0, 1'b1);
        op(3'h5, 8'h00, 1'b0, 32'h0, 1'b1);
        @(negedge core_clk);
        test_done;
    end
endmodule
bind pde_engine pde_engine_checker pde_engine_checker_inst (.core_clk, .reset_n, .addr_wr,
    .addr_wdata, .flag_wdata, .product_info_chip_select, .product_info_enable,
    .product_info_address_field, .product_info_flag, .product_info_data_register, .busy,
    .ee_req, .ee_wr, .ee_cs, .ee_addr, .ee_done, .ee_rdata);
